// ==== tb.sv ====
// Self-checking testbench for the serial clocking and start-bit recovery block.
`timescale 1ns/1ps
module tb;
  import usc_pkg::*;
  // ==========================================================
  // Design, partner and pin wiring
  logic clk;
  logic reset_n;
  usc_cfg_t cfg;
  logic [7:0] txData;
  logic txValid;
  logic txReady;
  logic [7:0] rxData;
  logic rxValid;
  usc_rx_flags_t rxFlags;
  logic txComplete;
  logic startAccepted;
  logic startRejected;
  logic pinDrive;
  logic sharedClockOut;
  logic sharedClockOe;
  logic txLine;
  logic tbRx;
  logic miso;
  logic clear;
  logic lastSck;
  logic [7:0] sendByte;
  logic [7:0] gotByte;
  int frames;
  int miscompares;
  int nCompared;
  int cyc;
  int accN;
  int rejN;
  int doneN;
  int rxN;
  int half;
  int runLen;
  logic pin;
  logic rxLine;
  logic pph;

  // The pin level follows whichever party enables its driver.
  assign pin = sharedClockOe ? sharedClockOut : pinDrive;
  assign rxLine = (cfg.mode == ModeAsync) ? tbRx : miso;
  assign pph = (cfg.mode == ModeSpiMaster) ? cfg.clockPhaseSelect : 1'b1;

  usc_core #(.FifoDepth(8)) dut_u (.clk(clk), .reset_n(reset_n), .cfg(cfg), .txData(txData),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .rxFlags(rxFlags), .txComplete(txComplete), .startAccepted(startAccepted),
    .startRejected(startRejected), .sharedClockIn(pin), .sharedClockOut(sharedClockOut),
    .sharedClockOe(sharedClockOe), .txLine(txLine), .rxLine(rxLine));

  usc_partner peer_u (.sck(pin), .inv(cfg.pinInversionEnable), .ph(pph),
    .lsbFirst(cfg.bitOrderSelect), .clear(clear), .sendByte(sendByte), .mosi(txLine),
    .miso(miso), .gotByte(gotByte), .frames(frames));

  // ==========================================================
  // Clock, watchers and hang guard
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts pulses and measures clock half periods from values settled before each edge.
  always @(posedge clk)
  begin
    accN += (startAccepted === 1'b1);
    rejN += (startRejected === 1'b1);
    doneN += (txComplete === 1'b1);
    rxN += (rxValid === 1'b1);
    if (sharedClockOut !== lastSck)
    begin
      half = runLen;
      runLen = 1;
    end
    else
      runLen++;
    lastSck = sharedClockOut;
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // ==========================================================
  // Access tasks
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Resets the design under a new configuration and rewinds the partner.
  task automatic setup(input usc_mode_t m, input logic mst, input logic inv, input logic ph,
                       input logic ord, input logic [1:0] spd, input logic [15:0] baud);
    @(negedge clk);
    reset_n = 1'b0;
    cfg = '{m, mst, inv, ph, ord, spd, baud};
    pinDrive = inv;
    tbRx = 1'b1;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    clear = 1'b1;
    accN = 0;
    rejN = 0;
    doneN = 0;
    rxN = 0;
    @(negedge clk);
    clear = 1'b0;
  endtask

  // Holds a byte on the fill side until the FIFO takes it.
  task automatic push(input logic [7:0] b);
    txData = b;
    txValid = 1'b1;
    while (txReady !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    txValid = 1'b0;
  endtask

  task automatic waitRx(input int target);
    int k;
    k = 0;
    while (rxN < target && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    repeat (20) @(negedge clk);
    check("frame end seen", 16'(rxN), 16'(target));
  endtask

  // Drives an idle line, then a low level lasting the given number of sample ticks.
  task automatic startBit(input int lowTicks);
    repeat (40) @(negedge clk);
    tbRx = 1'b0;
    repeat (lowTicks * 2) @(negedge clk);
    tbRx = 1'b1;
    repeat (60) @(negedge clk);
  endtask

  // ==========================================================
  // Test sequence
  initial
  begin
    int n;
    logic r;
    reset_n = 1'b0;
    cfg = '0;
    txData = 8'h00;
    txValid = 1'b0;
    pinDrive = 1'b0;
    tbRx = 1'b1;
    clear = 1'b0;
    sendByte = 8'h00;
    lastSck = 1'b0;
    {miscompares, nCompared, cyc, accN, rejN, doneN, rxN, half, runLen} = '0;
    repeat (20) @(negedge clk);
    // Master frames in both clocked modes over inversion and phase, both orders in SPI only; divisor 8, fraction zero.
    for (int i = 0; i < 16; i++)
    begin
      sendByte = 8'hC5 + 8'(i);
      setup(i[3] ? ModeSpiMaster : ModeSync, 1'b1, i[0], i[1], i[3] ? i[2] : 1'b1,
            RxModeNormal, 16'h0200);
      push(8'h96 ^ 8'(i));
      waitRx(1);
      check("oe master", 16'(sharedClockOe), 16'h0001);
      check("rx data", 16'(rxData), 16'(sendByte));
      check("peer data", 16'(gotByte), 16'(8'h96 ^ 8'(i)));
      check("peer frames", 16'(frames), 16'h0001);
      check("half period", 16'(half), 16'h0008);
      check("error flags", 16'(rxFlags), 16'h0000);
      check("tx complete", 16'(doneN), 16'h0001);
      check("clock idle", 16'(sharedClockOut), 16'(i[0]));
    end
    // Nine bytes offered back to back: eight queue behind the one in flight.
    sendByte = 8'h3C;
    setup(ModeSpiMaster, 1'b1, 1'b0, 1'b0, 1'b0, RxModeNormal, 16'h0200);
    txValid = 1'b1;
    txData = 8'hA0;
    n = 0;
    repeat (12)
    begin
      r = txReady;
      @(negedge clk);
      if (r === 1'b1)
      begin
        n++;
        txData = txData + 8'h01;
      end
    end
    txValid = 1'b0;
    check("bytes taken", 16'(n), 16'h0009);
    waitRx(9);
    check("burst frames", 16'(frames), 16'h0009);
    check("burst last", 16'(gotByte), 16'h00A8);
    check("burst complete", 16'(doneN), 16'h0001);
    // Clock slave: a bogus divisor, and a pin clock of 12 cycles, slower than a quarter.
    for (int i = 0; i < 2; i++)
    begin
      sendByte = 8'h69 + 8'(i);
      setup(ModeSync, 1'b0, i[0], 1'b1, 1'b1, RxModeNormal, 16'h0040);
      push(8'h2D + 8'(i));
      repeat (4) @(negedge clk);
      repeat (16)
      begin
        repeat (6) @(negedge clk);
        pinDrive = ~pinDrive;
      end
      waitRx(1);
      check("oe slave", 16'(sharedClockOe), 16'h0000);
      check("slave rx", 16'(rxData), 16'(sendByte));
      check("slave peer", 16'(gotByte), 16'(8'h2D + 8'(i)));
    end
    // Start votes: one low run too short, then one just long enough, per speed mode.
    for (int s = 0; s < 2; s++)
    begin
      setup(ModeAsync, 1'b0, 1'b0, 1'b0, 1'b0, 2'(s), 16'h0080);
      startBit(s ? 4 : 8);
      check("rejected", 16'(rejN), 16'h0001);
      check("early accept", 16'(accN), 16'h0000);
      startBit(s ? 5 : 9);
      check("accepted", 16'(accN), 16'h0001);
      check("one reject", 16'(rejN), 16'h0001);
    end
    wrap_up();
  end
endmodule

// ==== usc_core.sv ====
// Clocking, SPI-style master and start-bit recovery of a serial transceiver.
//
// Notes on behaviour
// - Pin direction picks clock master or slave.
// - Sample on edge opposite the launch edge.
// - No inversion: launch rising, sample falling.
// - Inversion: launch falling, sample rising.
// - Slave speed follows external clock only.
// - External clock below quarter of peripheral.
// - SPI frames are exactly eight data bits.
// - Order bit selects LSB or MSB first.
// - SPI clock from baud generator, full-period bits.
// - SPI receiver samples mid hold period.
// - Edge roles follow inversion and phase table.
// - Leading edge is first edge of cycle.
// - SPI transmit path behaves like normal.
// - SPI error flags always read zero.
// - No collision, double speed, multi-master, select.
// - Async sampling at 16x or 8x.
// - Falling edge from idle starts detection.
// - Vote on samples 8-10 or 4-6.
// - Two of three low accepts start.
// - Accepted start pulses startAccepted; detector returns to idle.
// - Synchronous mode uses integer divisor only.
// - Master clock is peripheral over twice divisor.
`timescale 1ns/1ps
module usc_core #(
  parameter int FifoDepth = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire usc_pkg::usc_cfg_t cfg,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid,
  output usc_pkg::usc_rx_flags_t rxFlags,
  output logic txComplete,
  output logic startAccepted,
  output logic startRejected,
  input wire logic sharedClockIn,
  output logic sharedClockOut,
  output logic sharedClockOe,
  output logic txLine,
  input wire logic rxLine
);
  import usc_pkg::*;

  if (FifoDepth < 2 || (FifoDepth & (FifoDepth - 1)) != 0)
  begin
    $error("FifoDepth must be a power of two");
  end

  // ==========================================================
  // Input synchronisers
  logic [1:0] clkSync_q;
  logic [1:0] rxSync_q;
  logic clkPrev_q;

  // Clock pin flops have no reset, so they hold the idle level and no false edge follows.
  always_ff @(posedge clk)
  begin
    clkSync_q <= {clkSync_q[0], sharedClockIn};
    clkPrev_q <= clkSync_q[1];
  end

  // The data line flops idle high like the line itself.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      rxSync_q <= 2'h3;
    else
      rxSync_q <= {rxSync_q[0], rxLine};
  end

  logic rxIn;
  assign rxIn = rxSync_q[1];

  // ==========================================================
  // Transmit FIFO
  logic [7:0] fifoData;
  logic fifoValid;
  logic fifoPop;

  usc_fifo #(.Width(8), .Depth(FifoDepth)) txFifo (
    .clk(clk),
    .reset_n(reset_n),
    .inData(txData),
    .inValid(txValid),
    .inReady(txReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // ==========================================================
  // Bit clock generation and edge events
  logic [BaudIntW-1:0] divCnt_q;
  logic [BaudIntW-1:0] baudInt;
  logic halfTick;
  logic masterMode;
  logic genClk_q;
  logic risingEv;
  logic fallingEv;
  logic launchEv;
  logic sampleEv;
  logic busy_q;

  assign baudInt = cfg.baud[BaudW-1:BaudFracW];
  assign masterMode = cfg.clockPinOutput;
  assign halfTick = (divCnt_q + 1'b1 >= baudInt);

  // Half-period divider: the clock toggles every divisor cycles.
  always_ff @(posedge clk)
  begin
    if (!reset_n || !busy_q)
      divCnt_q <= '0;
    else if (halfTick)
      divCnt_q <= '0;
    else
      divCnt_q <= divCnt_q + 1'b1;
  end

  // Generated clock idles low; it toggles only while a frame runs.
  always_ff @(posedge clk)
  begin
    if (!reset_n || !busy_q)
      genClk_q <= 1'b0;
    else if (halfTick)
      genClk_q <= ~genClk_q;
  end

  // Edges are pin edges: from the divider in master mode, the synchronised pin in slave mode.
  always_comb
  begin
    if (masterMode)
    begin
      risingEv = busy_q && halfTick && (genClk_q == cfg.pinInversionEnable);
      fallingEv = busy_q && halfTick && (genClk_q != cfg.pinInversionEnable);
    end
    else
    begin
      risingEv = clkSync_q[1] && !clkPrev_q;
      fallingEv = !clkSync_q[1] && clkPrev_q;
    end
  end

  // Leading edge is rising without inversion, falling with it.
  logic leadEv;
  logic trailEv;
  assign leadEv = cfg.pinInversionEnable ? fallingEv : risingEv;
  assign trailEv = cfg.pinInversionEnable ? risingEv : fallingEv;

  // Synchronous mode launches on the leading edge; SPI follows phase.
  always_comb
  begin
    if (cfg.mode == ModeSpiMaster && !cfg.clockPhaseSelect)
    begin
      sampleEv = leadEv;
      launchEv = trailEv;
    end
    else
    begin
      launchEv = leadEv;
      sampleEv = trailEv;
    end
  end

  assign sharedClockOut = genClk_q ^ cfg.pinInversionEnable;
  assign sharedClockOe = masterMode && cfg.mode != ModeAsync;

  // ==========================================================
  // Synchronous and SPI-style shifter
  logic [7:0] txShift_q;
  logic [7:0] rxShift_q;
  logic [3:0] bitCnt_q;
  logic [3:0] launchCnt_q;
  logic syncMode;
  logic startFrame;
  logic endFrame;

  assign syncMode = cfg.mode != ModeAsync;
  assign startFrame = syncMode && !busy_q && fifoValid;
  assign fifoPop = startFrame;
  assign endFrame = busy_q && trailEv && bitCnt_q + 4'(sampleEv) == 4'(SpiBits);

  // Busy spans one eight-bit frame.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      busy_q <= 1'b0;
    else if (startFrame)
      busy_q <= 1'b1;
    else if (endFrame)
      busy_q <= 1'b0;
  end

  // Load and launch: phase 0 presents the first bit before the first edge.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      txShift_q <= 8'hFF;
      txLine <= 1'b1;
      launchCnt_q <= 4'h0;
    end
    else if (startFrame)
    begin
      txShift_q <= fifoData;
      launchCnt_q <= 4'h0;
      if (cfg.mode == ModeSpiMaster && !cfg.clockPhaseSelect)
      begin
        txLine <= cfg.bitOrderSelect ? fifoData[0] : fifoData[7];
        txShift_q <= cfg.bitOrderSelect ? {1'b1, fifoData[7:1]} : {fifoData[6:0], 1'b1};
        launchCnt_q <= 4'h1;
      end
    end
    else if (busy_q && launchEv && launchCnt_q < 4'(SpiBits))
    begin
      txLine <= cfg.bitOrderSelect ? txShift_q[0] : txShift_q[7];
      txShift_q <= cfg.bitOrderSelect ? {1'b1, txShift_q[7:1]} : {txShift_q[6:0], 1'b1};
      launchCnt_q <= launchCnt_q + 1'b1;
    end
  end

  // Sampling on the opposite edge, assembled in the same bit order.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rxShift_q <= 8'h00;
      bitCnt_q <= 4'h0;
    end
    else if (startFrame)
      bitCnt_q <= 4'h0;
    else if (busy_q && sampleEv)
    begin
      rxShift_q <= cfg.bitOrderSelect ? {rxIn, rxShift_q[7:1]} : {rxShift_q[6:0], rxIn};
      bitCnt_q <= bitCnt_q + 1'b1;
    end
  end

  // Received byte and completion pulse.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rxData <= 8'h00;
      rxValid <= 1'b0;
      txComplete <= 1'b0;
    end
    else
    begin
      rxValid <= endFrame;
      txComplete <= endFrame && !fifoValid;
      if (endFrame && sampleEv)
        rxData <= cfg.bitOrderSelect ? {rxIn, rxShift_q[7:1]} : {rxShift_q[6:0], rxIn};
      else if (endFrame)
        rxData <= rxShift_q; // Phase 0 took its last bit on the leading edge.
    end
  end

  // Error flags are unused in every mode this block serves.
  assign rxFlags = '0;

  // ==========================================================
  // Asynchronous start-bit recovery
  typedef enum logic [1:0] {StIdle, StArmed, StDetect} usc_st_t;
  usc_st_t st_q;
  logic [BaudW-1:0] smpCnt_q;
  logic [BaudW-1:0] smpDiv;
  logic smpTick;
  logic [4:0] smpNum_q;
  logic [1:0] lowVotes_q;
  logic [4:0] voteFirst;
  logic dbl;

  assign dbl = cfg.receiveSpeedMode == RxModeDouble;
  assign voteFirst = dbl ? VoteFirstDouble : VoteFirstNormal;
  assign smpDiv = (cfg.baud >> BaudFracW) == 0 ? BaudW'(1) : (cfg.baud >> BaudFracW);
  assign smpTick = smpCnt_q + 1'b1 >= smpDiv;

  // Sample-rate tick: divisor integer part counts per sample.
  always_ff @(posedge clk)
  begin
    if (!reset_n || smpTick)
      smpCnt_q <= '0;
    else
      smpCnt_q <= smpCnt_q + 1'b1;
  end

  // Idle needs a high sample before a falling edge is armed.
  always_ff @(posedge clk)
  begin
    if (!reset_n || cfg.mode != ModeAsync)
    begin
      st_q <= StIdle;
      smpNum_q <= 5'h0;
      lowVotes_q <= 2'h0;
    end
    else if (smpTick)
    begin
      unique case (st_q)
        StIdle:
          if (rxIn) st_q <= StArmed;
        StArmed:
          if (!rxIn)
          begin
            st_q <= StDetect;
            smpNum_q <= 5'h1;
            lowVotes_q <= 2'h0;
          end
        StDetect:
        begin
          smpNum_q <= smpNum_q + 1'b1;
          if (smpNum_q + 1'b1 >= voteFirst && !rxIn && lowVotes_q != 2'h3)
            lowVotes_q <= lowVotes_q + 1'b1;
          if (smpNum_q + 1'b1 == voteFirst + 5'h2)
            st_q <= StIdle;
        end
      endcase
    end
  end

  logic voteDone;
  logic lastLow;
  assign voteDone = smpTick && st_q == StDetect && smpNum_q + 1'b1 == voteFirst + 5'h2;
  assign lastLow = !rxIn;

  // Decision pulses: two or three low samples accept the start.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      startAccepted <= 1'b0;
      startRejected <= 1'b0;
    end
    else
    begin
      startAccepted <= voteDone && (lowVotes_q + 2'(lastLow)) >= 2'h2;
      startRejected <= voteDone && (lowVotes_q + 2'(lastLow)) < 2'h2;
    end
  end

  // ==========================================================
  // Assertions
  property p_flagsZero;
    @(posedge clk) disable iff (!reset_n) rxFlags == 3'h0;
  endproperty
  a_flagsZero: assert property (p_flagsZero) else $error("error flags not zero");

  property p_slaveNoDrive;
    @(posedge clk) disable iff (!reset_n) !cfg.clockPinOutput |-> !sharedClockOe;
  endproperty
  a_slaveNoDrive: assert property (p_slaveNoDrive) else $error("slave drives clock");

  property p_oneRole;
    @(posedge clk) disable iff (!reset_n) !(launchEv && sampleEv);
  endproperty
  a_oneRole: assert property (p_oneRole) else $error("launch and sample same edge");

  property p_noInvLaunch;
    @(posedge clk) disable iff (!reset_n || cfg.mode != ModeSync || !masterMode)
      (!cfg.pinInversionEnable && launchEv) |=> sharedClockOut;
  endproperty
  a_noInvLaunch: assert property (p_noInvLaunch) else $error("launch not rising");

  property p_invLaunch;
    @(posedge clk) disable iff (!reset_n || cfg.mode != ModeSync || !masterMode)
      (cfg.pinInversionEnable && launchEv) |=> !sharedClockOut;
  endproperty
  a_invLaunch: assert property (p_invLaunch) else $error("launch not falling");

  property p_spiPhase0;
    @(posedge clk) disable iff (!reset_n)
      (cfg.mode == ModeSpiMaster && !cfg.clockPhaseSelect && sampleEv) |-> leadEv;
  endproperty
  a_spiPhase0: assert property (p_spiPhase0) else $error("phase 0 sample wrong");

  property p_halfPeriod;
    @(posedge clk) disable iff (!reset_n)
      (masterMode && busy_q && halfTick && baudInt > 1) |=> !halfTick;
  endproperty
  a_halfPeriod: assert property (p_halfPeriod) else $error("divider too fast");

  property p_acceptOnlyVote;
    @(posedge clk) disable iff (!reset_n) startAccepted |-> $past(voteDone);
  endproperty
  a_acceptOnlyVote: assert property (p_acceptOnlyVote) else $error("accept without vote");

  sequence s_detectStart;
    st_q == StArmed && smpTick && !rxIn;
  endsequence
  property p_detect;
    @(posedge clk) disable iff (!reset_n || cfg.mode != ModeAsync)
      s_detectStart |=> st_q == StDetect && smpNum_q == 5'h1;
  endproperty
  a_detect: assert property (p_detect) else $error("start not detected");
endmodule

// ==== usc_fifo.sv ====
// Parameterised valid/ready FIFO for the transmit data path.
`timescale 1ns/1ps
module usc_fifo #(
  parameter int Width = 8,
  parameter int Depth = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [Width-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [Width-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AddrW = (Depth > 1) ? $clog2(Depth) : 1;

  // Depth must be a power of two for the wrapping pointers.
  if (Depth < 2 || (Depth & (Depth - 1)) != 0)
  begin
    $error("Depth must be a power of two");
  end

  logic [Width-1:0] mem [Depth];
  logic [AddrW:0] wrPtr_q;
  logic [AddrW:0] rdPtr_q;
  logic pushOk;
  logic popOk;

  // Full and empty come from the extra wrap bit.
  assign outValid = wrPtr_q != rdPtr_q;
  assign inReady = !((wrPtr_q[AddrW] != rdPtr_q[AddrW]) &&
                     (wrPtr_q[AddrW-1:0] == rdPtr_q[AddrW-1:0]));
  assign pushOk = inValid && inReady;
  assign popOk = outValid && outReady;
  assign outData = mem[rdPtr_q[AddrW-1:0]];

  // Storage write.
  always_ff @(posedge clk)
  begin
    if (pushOk) mem[wrPtr_q[AddrW-1:0]] <= inData;
  end

  // Pointer update.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      if (pushOk) wrPtr_q <= wrPtr_q + 1'b1;
      if (popOk) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule

// ==== usc_partner.sv ====
// Behavioural far-side serial slave that trades one byte per eight sample edges.
`timescale 1ns/1ps
module usc_partner (
  input wire logic sck,
  input wire logic inv,
  input wire logic ph,
  input wire logic lsbFirst,
  input wire logic clear,
  input wire logic [7:0] sendByte,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] gotByte,
  output int frames
);
  logic [7:0] shiftQ;
  int cnt;

  // Maps a bit position in the frame to a data bit index.
  function automatic int idx(input int i);
    return lsbFirst ? i : 7 - i;
  endfunction

  // Clearing rewinds the shifter and presents the first bit ahead of the first edge.
  always @(posedge clear)
  begin
    cnt = 0;
    frames = 0;
    gotByte = 8'h00;
    miso = sendByte[idx(0)];
  end

  // Samples on the same edge as the master and launches on the other one.
  always @(sck)
  begin
    if (sck === (inv ~^ ph))
    begin
      shiftQ[idx(cnt)] = mosi;
      cnt++;
      if (cnt == 8)
      begin
        gotByte = shiftQ;
        frames++;
        cnt = 0;
      end
    end
    else
      miso = sendByte[idx(cnt)];
  end
endmodule

// ==== usc_pkg.sv ====
// Package with constants and carrier types for the serial clocking block.
package usc_pkg;

  // ==========================================================
  // Baud divisor layout
  localparam int BaudW = 16;
  localparam int BaudFracW = 6;
  localparam int BaudIntW = BaudW - BaudFracW;

  // ==========================================================
  // Receive speed modes and sample counts
  localparam logic [1:0] RxModeNormal = 2'h0;
  localparam logic [1:0] RxModeDouble = 2'h1;
  localparam logic [4:0] SamplesNormal = 5'h10;
  localparam logic [4:0] SamplesDouble = 5'h08;
  localparam logic [4:0] VoteFirstNormal = 5'h08;
  localparam logic [4:0] VoteFirstDouble = 5'h04;

  // ==========================================================
  // Frame and synchroniser constants
  localparam int SpiBits = 8;
  localparam int SlaveOversample = 4;

  // Operating modes of the block.
  typedef enum logic [1:0] {ModeAsync, ModeSync, ModeSpiMaster} usc_mode_t;

  // Configuration bits that steer the block.
  typedef struct packed {
    usc_mode_t mode;
    logic clockPinOutput;
    logic pinInversionEnable;
    logic clockPhaseSelect;
    logic bitOrderSelect;
    logic [1:0] receiveSpeedMode;
    logic [BaudW-1:0] baud;
  } usc_cfg_t;

  // Receive status flags.
  typedef struct packed {
    logic frameError;
    logic bufferOverflow;
    logic parityError;
  } usc_rx_flags_t;

endpackage
